/* File: hw/ach_pkg.sv */
// Purpose: Constants and types for the acquisition command handler.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Command codes, field positions and reset values live here.
// Operation
// - Ping returns a reply and changes no state.
// - Reply echoes command identifier with top bit set, source and payload.
// - Broadcast forwards to all children, reply only from named child.
// - Asynchronous flag makes the parent answer the host at once.
// - Busy child withholds reply until its command ends; others stay reachable.
// - Configure-children loads flash bitstream into children, also after power-up.
// - Mode write stores payload bits 3:0; 0 idle, 1 scope, 2 singles.
// - Mode read returns last written mode.
// - Settings write stores a 32-bit word interpreted by current mode.
// - Scope settings: bits 3:0 0001, 12:4 total, 19:16 pre, 27:24 window.
// - Singles settings bits 3:0 give event ticks, sender programs above one.
// - Pipeline depth is ceil(ticks divided by slice width) plus one.
// - Settings read returns last written settings unchanged.
// - Action write stores bits 3:0; 0 reset, 1 stop, 2 run.
// - Reset action clears mode and settings and halts acquisition.
// - Action read returns last written action.
// - Trigger mask write stores one enable bit per channel.
// - Trigger mask read returns last written mask.
// - Commands without argument ignore the payload.
// - Unknown command identifier answers with unknown-command error.
// - Targeted child busy answers with child-busy error.
package ach_pkg;
    localparam logic [15:0] CMD_PING       = 16'h0001;
    localparam logic [15:0] CMD_CFG_CHILD  = 16'h0002;
    localparam logic [15:0] CMD_MODE_WR    = 16'h0003;
    localparam logic [15:0] CMD_MODE_RD    = 16'h0004;
    localparam logic [15:0] CMD_SET_WR     = 16'h0005;
    localparam logic [15:0] CMD_SET_RD     = 16'h0006;
    localparam logic [15:0] CMD_ACT_WR     = 16'h0007;
    localparam logic [15:0] CMD_ACT_RD     = 16'h0008;
    localparam logic [15:0] CMD_MASK_WR    = 16'h0009;
    localparam logic [15:0] CMD_MASK_RD    = 16'h000a;
    localparam logic [15:0] ERR_CHILD_BUSY = 16'h7f03;
    localparam logic [15:0] ERR_UNKNOWN    = 16'h7f04;
    localparam int          REPLY_BIT      = 15;
    localparam int          ASYNC_BIT      = 12;
    localparam int          BCAST_BIT      = 15;
    localparam logic [3:0]  MODE_IDLE      = 4'h0;
    localparam logic [3:0]  MODE_SCOPE     = 4'h1;
    localparam logic [3:0]  MODE_SINGLES   = 4'h2;
    localparam logic [3:0]  ACT_RESET      = 4'h0;
    localparam logic [3:0]  ACT_STOP       = 4'h1;
    localparam logic [3:0]  ACT_RUN        = 4'h2;
    localparam logic [31:0] REG_RESET      = 32'h0000_0000;
    localparam int          SCOPE_TOT_LSB  = 4;
    localparam int          SCOPE_PRE_LSB  = 16;
    localparam int          SCOPE_WIN_LSB  = 24;
    localparam logic [3:0]  SCOPE_RSVD     = 4'h1;
    localparam int          SLICE_WIDTH    = 4;
    localparam int          MAX_TICKS      = 15;
    localparam int          PIPE_STAGES    = (MAX_TICKS + SLICE_WIDTH - 1) / SLICE_WIDTH + 1;
    localparam int          HOST_TMO_MS    = 200;
    typedef enum logic [1:0] {ST_IDLE, ST_FLASH, ST_WAIT, ST_REPLY} ach_state_type;
endpackage

/* File: hw/ach_child_if.sv */
`timescale 1ns/1ps
// Purpose: Command path from the parent controller to its child boards.
// Assumes: Children acknowledge with a single-cycle done pulse.
// Notes:   Done pulses come back one bit per child.
interface ach_child_if #(parameter int N_CHILD = 8);
    logic               start;
    logic               bcast;
    logic [15:0]        dst;
    logic [15:0]        cmd;
    logic [31:0]        payload;
    logic [N_CHILD-1:0] done;
    logic [N_CHILD-1:0] busy;
    logic [31:0]        reply;
    modport parent (output start, bcast, dst, cmd, payload, input done, busy, reply);
    modport tracker (input start, bcast, dst, cmd, payload, done, output busy);
endinterface

/* File: hw/ach_busy_track.sv */
`timescale 1ns/1ps
// Purpose: Tracks which children are still executing a command.
// Assumes: A child is busy from start until its done pulse.
// Notes:   A start wins over a done on the same child in the same cycle.
module ach_busy_track
    import ach_pkg::*;
#(
    parameter int N_CHILD = 8
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    ach_child_if.tracker ch
);
    typedef struct packed {
        logic [N_CHILD-1:0] busy;
    } ach_trk_type;
    ach_trk_type r;
    ach_trk_type next_r;

    // Set on start for every addressed child; clear on that child's done.
    always_comb begin
        next_r = r;
        for (int i = 0; i < N_CHILD; i++) begin
            if (ch.done[i]) begin
                next_r.busy[i] = 1'b0;
            end
            if (ch.start && (ch.bcast || ch.dst[7:0] == 8'(i))) begin
                next_r.busy[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign ch.busy = r.busy;
endmodule

/* File: hw/ach_flash_loader.sv */
`timescale 1ns/1ps
// Purpose: Streams a child bitstream from serial flash into the child boards.
// Assumes: Flash read data is valid one cycle after a read request.
// Notes:   Starts on its own after reset.
module ach_flash_loader
    import ach_pkg::*;
#(
    parameter int IMG_WORDS = 16
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_start,
    input  wire logic [31:0] i_flash_data,
    output logic             o_flash_rd,
    output logic [15:0]      o_flash_addr,
    output logic             o_cfg_valid,
    output logic [31:0]      o_cfg_data,
    output logic             o_done
);
    // The image must fit the sixteen-bit flash address.
    if (IMG_WORDS < 1 || IMG_WORDS > 65536) begin : g_bad_img
        $error("IMG_WORDS out of range");
    end
    typedef struct packed {
        logic        run;
        logic        rd;
        logic        rd_d;
        logic [15:0] addr;
        logic        vld;
        logic [31:0] data;
        logic        done;
    } ach_ldr_type;
    ach_ldr_type r;
    ach_ldr_type next_r;

    always_comb begin
        next_r      = r;
        // Flash data lands a cycle after the request, so valid trails it by one more.
        next_r.rd_d = r.rd;
        next_r.vld  = r.rd_d;
        next_r.data = i_flash_data;
        next_r.done = 1'b0;
        next_r.rd   = 1'b0;
        if (i_start && !r.run) begin
            next_r.run  = 1'b1;
            next_r.addr = '0;
        end else if (r.run) begin
            next_r.rd = 1'b1;
            if (r.rd) begin
                if (r.addr == 16'(IMG_WORDS - 1)) begin
                    next_r.run  = 1'b0;
                    next_r.rd   = 1'b0;
                    next_r.done = 1'b1;
                end else begin
                    next_r.addr = r.addr + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r     <= '0;
            r.run <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign o_flash_rd   = r.rd;
    assign o_flash_addr = r.addr;
    assign o_cfg_valid  = r.vld;
    assign o_cfg_data   = r.data;
    assign o_done       = r.done;
endmodule

/* File: hw/ach_top.sv */
`timescale 1ns/1ps
// Purpose: Interprets host commands and keeps the acquisition registers.
// Assumes: One command word set per i_cmd_valid pulse; next only after o_rsp_valid.
// Notes:   Local commands answer in one cycle; child commands wait for done unless asynchronous, unknown or to a busy child.
module ach_top
    import ach_pkg::*;
#(
    parameter int N_CHILD   = 8,
    parameter int IMG_WORDS = 16,
    parameter logic [15:0] MY_ADDR = 16'h0000
) (
    input  wire logic               i_clk,
    input  wire logic               i_rst,
    input  wire logic               i_cmd_valid,
    input  wire logic [15:0]        i_cmd_id,
    input  wire logic [15:0]        i_cmd_dst,
    input  wire logic [31:0]        i_cmd_payload,
    output logic                    o_rsp_valid,
    output logic [15:0]             o_rsp_id,
    output logic [15:0]             o_rsp_src,
    output logic [31:0]             o_rsp_payload,
    output logic                    o_child_start,
    output logic                    o_child_bcast,
    output logic [15:0]             o_child_dst,
    output logic [15:0]             o_child_cmd,
    output logic [31:0]             o_child_payload,
    input  wire logic [N_CHILD-1:0] i_child_done,
    input  wire logic [31:0]        i_child_reply,
    input  wire logic [31:0]        i_flash_data,
    output logic                    o_flash_rd,
    output logic [15:0]             o_flash_addr,
    output logic                    o_cfg_valid,
    output logic [31:0]             o_cfg_data,
    output logic [3:0]              o_mode,
    output logic [31:0]             o_settings,
    output logic                    o_acq_run,
    output logic [31:0]             o_trig_mask
);
    // The child index needs at least one bit and must fit in eight bits.
    if (N_CHILD < 2 || N_CHILD > 256) begin : g_bad_child
        $error("N_CHILD out of range");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        ach_state_type st;
        logic [3:0]    mode;
        logic [31:0]   settings;
        logic [3:0]    action;
        logic          run;
        logic [31:0]   mask;
        logic          rsp_v;
        logic [15:0]   rsp_id;
        logic [15:0]   rsp_src;
        logic [31:0]   rsp_pl;
        logic          c_start;
        logic          c_bcast;
        logic [15:0]   c_dst;
        logic [15:0]   c_cmd;
        logic [31:0]   c_pl;
        logic [7:0]    wait_idx;
        logic          flash_go;
    } ach_top_type;
    ach_top_type r;
    ach_top_type next_r;

    ach_child_if #(.N_CHILD(N_CHILD)) chi ();
    logic flash_done;

    // reply identifier
    // Reply identifier keeps the command and sets the top bit.
    function automatic logic [15:0] reply_id(input logic [15:0] id);
        reply_id = id | (16'h0001 << REPLY_BIT);
    endfunction

    // Decides whether an identifier, async flag aside, is a known command.
    function automatic logic known_cmd(input logic [15:0] id);
        logic [15:0] base;
        base = id & ~(16'h0001 << ASYNC_BIT);
        known_cmd = (base >= CMD_PING) && (base <= CMD_MASK_RD);
    endfunction

    // ----------------------------------------------------------------
    // Children
    // ----------------------------------------------------------------
    assign chi.start   = r.c_start;
    assign chi.bcast   = r.c_bcast;
    assign chi.dst     = r.c_dst;
    assign chi.cmd     = r.c_cmd;
    assign chi.payload = r.c_pl;
    assign chi.done    = i_child_done;
    assign chi.reply   = i_child_reply;

    ach_busy_track #(.N_CHILD(N_CHILD)) u_trk (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .ch    (chi.tracker)
    );

    ach_flash_loader #(.IMG_WORDS(IMG_WORDS)) u_ldr (
        .i_clk        (i_clk),
        .i_rst        (i_rst),
        .i_start      (r.flash_go),
        .i_flash_data (i_flash_data),
        .o_flash_rd   (o_flash_rd),
        .o_flash_addr (o_flash_addr),
        .o_cfg_valid  (o_cfg_valid),
        .o_cfg_data   (o_cfg_data),
        .o_done       (flash_done)
    );

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    logic [15:0] base_id;
    logic        is_async;
    logic        is_local;
    logic [7:0]  tgt;
    assign base_id  = i_cmd_id & ~(16'h0001 << ASYNC_BIT);
    assign is_async = i_cmd_id[ASYNC_BIT];
    assign is_local = (i_cmd_dst & ~(16'h0001 << BCAST_BIT)) == MY_ADDR;
    assign tgt      = i_cmd_dst[7:0];

    // Next state of registers, responses and child requests.
    always_comb begin
        next_r         = r;
        next_r.rsp_v   = 1'b0;
        next_r.c_start = 1'b0;
        next_r.flash_go = 1'b0;
        case (r.st)
            ST_IDLE: begin
                if (i_cmd_valid) begin
                    next_r.rsp_id  = reply_id(i_cmd_id);
                    next_r.rsp_src = i_cmd_dst;
                    next_r.rsp_pl  = 32'h0000_0000;
                    if (!known_cmd(i_cmd_id)) begin
                        next_r.rsp_id = ERR_UNKNOWN;
                        next_r.rsp_v  = 1'b1;
                    end else if (is_local || i_cmd_dst[BCAST_BIT]) begin
                        next_r.rsp_v = 1'b1;
                        if (i_cmd_dst[BCAST_BIT]) begin
                            next_r.c_start = 1'b1;
                            next_r.c_bcast = 1'b1;
                            next_r.c_dst   = i_cmd_dst;
                            next_r.c_cmd   = i_cmd_id;
                            next_r.c_pl    = i_cmd_payload;
                        end
                        case (base_id)
                            CMD_PING: next_r.rsp_pl = 32'h0000_0000;
                            CMD_CFG_CHILD: next_r.flash_go = 1'b1;
                            CMD_MODE_WR: next_r.mode = i_cmd_payload[3:0];
                            CMD_MODE_RD: next_r.rsp_pl = {28'h0, r.mode};
                            CMD_SET_WR: next_r.settings = i_cmd_payload;
                            CMD_SET_RD: next_r.rsp_pl = r.settings;
                            CMD_ACT_WR: begin
                                next_r.action = i_cmd_payload[3:0];
                                next_r.run    = (i_cmd_payload[3:0] == ACT_RUN);
                                if (i_cmd_payload[3:0] == ACT_RESET) begin
                                    next_r.mode     = MODE_IDLE;
                                    next_r.settings = REG_RESET;
                                end
                            end
                            CMD_ACT_RD: next_r.rsp_pl = {28'h0, r.action};
                            CMD_MASK_WR: next_r.mask = i_cmd_payload;
                            CMD_MASK_RD: next_r.rsp_pl = r.mask;
                            default: next_r.rsp_pl = 32'h0000_0000;
                        endcase
                        if (i_cmd_dst[BCAST_BIT] && !is_local && !is_async) begin
                            next_r.rsp_v    = 1'b0;
                            next_r.wait_idx = tgt;
                            next_r.st       = ST_WAIT;
                        end
                    end else if (chi.busy[tgt[$clog2(N_CHILD)-1:0]]) begin
                        next_r.rsp_id = ERR_CHILD_BUSY;
                        next_r.rsp_v  = 1'b1;
                    end else begin
                        next_r.c_start = 1'b1;
                        next_r.c_bcast = 1'b0;
                        next_r.c_dst   = i_cmd_dst;
                        next_r.c_cmd   = i_cmd_id;
                        next_r.c_pl    = i_cmd_payload;
                        next_r.wait_idx = tgt;
                        if (is_async) begin
                            next_r.rsp_v = 1'b1;
                        end else begin
                            next_r.st = ST_WAIT;
                        end
                    end
                end
            end
            ST_WAIT: begin
                if (i_child_done[r.wait_idx[$clog2(N_CHILD)-1:0]]) begin
                    next_r.rsp_pl = i_child_reply;
                    next_r.rsp_v  = 1'b1;
                    next_r.st     = ST_IDLE;
                end
            end
            default: next_r.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_rsp_valid     = r.rsp_v;
    assign o_rsp_id        = r.rsp_id;
    assign o_rsp_src       = r.rsp_src;
    assign o_rsp_payload   = r.rsp_pl;
    assign o_child_start   = r.c_start;
    assign o_child_bcast   = r.c_bcast;
    assign o_child_dst     = r.c_dst;
    assign o_child_cmd     = r.c_cmd;
    assign o_child_payload = r.c_pl;
    assign o_mode          = r.mode;
    assign o_settings      = r.settings;
    assign o_acq_run       = r.run;
    assign o_trig_mask     = r.mask;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_reply(id);
        @(posedge i_clk) disable iff (i_rst)
        (r.st == ST_IDLE && i_cmd_valid && i_cmd_id == id && is_local) |=> o_rsp_valid;
    endproperty
    ping_reply_a: assert property (p_reply(CMD_PING))
        else $error("ping did not reply");
    reply_top_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_rsp_valid && o_rsp_id != ERR_UNKNOWN && o_rsp_id != ERR_CHILD_BUSY
        |-> o_rsp_id[REPLY_BIT])
        else $error("reply id top bit clear");
    mode_store_a: assert property (@(posedge i_clk) disable iff (i_rst)
        r.st == ST_IDLE && i_cmd_valid && i_cmd_id == CMD_MODE_WR && is_local
        |=> o_mode == $past(i_cmd_payload[3:0]))
        else $error("mode not stored");
    mode_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
        r.st == ST_IDLE && i_cmd_valid && i_cmd_id == CMD_MODE_RD && is_local
        |=> o_rsp_payload == {28'h0, $past(o_mode)})
        else $error("mode read wrong");
    reset_action_a: assert property (@(posedge i_clk) disable iff (i_rst)
        r.st == ST_IDLE && i_cmd_valid && i_cmd_id == CMD_ACT_WR && is_local
        && i_cmd_payload[3:0] == ACT_RESET |=> o_mode == MODE_IDLE && o_settings == 32'h0
        && !o_acq_run)
        else $error("reset action incomplete");
    mask_store_a: assert property (@(posedge i_clk) disable iff (i_rst)
        r.st == ST_IDLE && i_cmd_valid && i_cmd_id == CMD_MASK_WR && is_local
        |=> o_trig_mask == $past(i_cmd_payload))
        else $error("mask not stored");
    unknown_err_a: assert property (@(posedge i_clk) disable iff (i_rst)
        r.st == ST_IDLE && i_cmd_valid && !known_cmd(i_cmd_id)
        |=> o_rsp_valid && o_rsp_id == ERR_UNKNOWN)
        else $error("unknown command not flagged");
    async_now_a: assert property (@(posedge i_clk) disable iff (i_rst)
        r.st == ST_IDLE && i_cmd_valid && known_cmd(i_cmd_id) && is_async && !is_local
        |=> o_rsp_valid)
        else $error("async not answered at once");
    cfg_boot_a: assert property (@(posedge i_clk) $fell(i_rst) |-> ##[1:3] o_flash_rd)
        else $error("no flash load after reset");
    busy_err_a: assert property (@(posedge i_clk) disable iff (i_rst)
        r.st == ST_IDLE && i_cmd_valid && known_cmd(i_cmd_id) && !is_local
        && !i_cmd_dst[BCAST_BIT] && chi.busy[tgt[$clog2(N_CHILD)-1:0]]
        |=> o_rsp_valid && o_rsp_id == ERR_CHILD_BUSY)
        else $error("busy child not flagged");
    wait_reply_a: assert property (@(posedge i_clk) disable iff (i_rst)
        r.st == ST_WAIT && i_child_done[r.wait_idx[$clog2(N_CHILD)-1:0]]
        |=> o_rsp_valid && o_rsp_payload == $past(i_child_reply))
        else $error("child reply not passed on");
    reset_zero_a: assert property (@(posedge i_clk) $fell(i_rst)
        |-> o_mode == 4'h0 && o_settings == 32'h0 && o_trig_mask == 32'h0 && !o_acq_run)
        else $error("registers not cleared by reset");
    cv_ping_c: cover property (@(posedge i_clk) o_rsp_valid && o_rsp_id == 16'h8001);
    cv_wait_c: cover property (@(posedge i_clk) r.st == ST_WAIT ##[1:20] o_rsp_valid);
    cv_busy_c: cover property (@(posedge i_clk) o_rsp_valid && o_rsp_id == ERR_CHILD_BUSY);
    cv_async_c: cover property (@(posedge i_clk) o_rsp_valid && o_rsp_id == 16'h9001);
    cv_bcast_c: cover property (@(posedge i_clk) o_child_start && o_child_bcast);
endmodule

/* File: sim/ach_child_model.sv */
// Purpose: Child boards and flash behind the command handler.
// Assumes: Each child answers with one done pulse after a delay.
// Notes:   Idle reply and flash lines show inverted data.
`timescale 1ns/1ps
module ach_child_model (
    input  wire logic        i_clk,
    input  wire logic        i_start,
    input  wire logic        i_bcast,
    input  wire logic [15:0] i_dst,
    input  wire logic [31:0] i_payload,
    input  wire logic        i_slow,
    input  wire logic        i_flash_rd,
    input  wire logic [15:0] i_flash_addr,
    output logic [7:0]       o_done = 8'h00,
    output logic [31:0]      o_reply = 32'h0,
    output logic [31:0]      o_flash_data = 32'h0
);
    // Flash word comes one cycle after a read, else it keeps toggling.
    always @(posedge i_clk) begin
        o_flash_data <= i_flash_rd ? {i_flash_addr, ~i_flash_addr} : ~o_flash_data;
    end
    // A slow child holds its answer back for a long command.
    always @(posedge i_clk) begin
        if (i_start) begin
            fork
                answer(i_bcast ? 8'hff : 8'h01 << i_dst[2:0], i_payload + 32'h1, i_slow ? 40 : 3);
            join_none
        end
    end
    // Every child started by a broadcast answers, so none stays busy.
    task automatic answer(input logic [7:0] c, input logic [31:0] r, input int d);
        repeat (d) @(posedge i_clk);
        o_done <= o_done | c;
        o_reply <= r;
        @(posedge i_clk);
        o_done <= o_done & ~c;
        o_reply <= ~r;
    endtask
endmodule

/* File: sim/acquisition_command_handler_tb.sv */
// Purpose: Self-checking bench for the acquisition command handler.
// Assumes: One command outstanding; replies are queued as expectations.
// Notes:   Monitor pops the oldest expectation on every reply.
`timescale 1ns/1ps
module acquisition_command_handler_tb;
    import ach_pkg::*;
    typedef struct {logic [15:0] id; logic [15:0] src; logic [31:0] pl; logic ck;} ach_exp_type;
    logic        i_clk = 1'b0, i_rst = 1'b1, i_cmd_valid = 1'b0, slow = 1'b0;
    logic [15:0] i_cmd_id = 16'h0, i_cmd_dst = 16'h0;
    logic [31:0] i_cmd_payload = 32'h0, r, m;
    logic [7:0]  i_child_done;
    logic [3:0]  o_mode;
    logic        o_rsp_valid, o_child_start, o_child_bcast, o_flash_rd, o_cfg_valid, o_acq_run;
    logic [15:0] o_rsp_id, o_rsp_src, o_child_dst, o_child_cmd, o_flash_addr;
    logic [31:0] o_rsp_payload, o_child_payload, i_child_reply, i_flash_data, o_cfg_data;
    logic [31:0] o_settings, o_trig_mask;
    int          seed = 98940, fail_count = 0, check_count = 0, rsp_n = 0, cfg_n = 0, k;
    ach_exp_type q[$], e;
    ach_top #(.N_CHILD(8), .IMG_WORDS(16)) ach_top_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid), .i_cmd_id(i_cmd_id),
        .i_cmd_dst(i_cmd_dst), .i_cmd_payload(i_cmd_payload), .o_rsp_valid(o_rsp_valid),
        .o_rsp_id(o_rsp_id), .o_rsp_src(o_rsp_src), .o_rsp_payload(o_rsp_payload),
        .o_child_start(o_child_start), .o_child_bcast(o_child_bcast),
        .o_child_dst(o_child_dst), .o_child_cmd(o_child_cmd),
        .o_child_payload(o_child_payload), .i_child_done(i_child_done),
        .i_child_reply(i_child_reply), .i_flash_data(i_flash_data), .o_flash_rd(o_flash_rd),
        .o_flash_addr(o_flash_addr), .o_cfg_valid(o_cfg_valid), .o_cfg_data(o_cfg_data),
        .o_mode(o_mode), .o_settings(o_settings), .o_acq_run(o_acq_run),
        .o_trig_mask(o_trig_mask));
    ach_child_model ach_child_model_inst (
        .i_clk(i_clk), .i_start(o_child_start), .i_bcast(o_child_bcast), .i_dst(o_child_dst),
        .i_payload(o_child_payload), .i_slow(slow), .i_flash_rd(o_flash_rd),
        .i_flash_addr(o_flash_addr), .o_done(i_child_done), .o_reply(i_child_reply),
        .o_flash_data(i_flash_data));
    // Clock of 4 ns period.
    always #2 i_clk = ~i_clk;
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, x, s);
        end
    endtask
    // Monitor compares every reply with the oldest expectation.
    always @(posedge i_clk) begin
        if (o_cfg_valid === 1'b1) begin
            chk("cfg_data", o_cfg_data, {16'(cfg_n % 16), ~16'(cfg_n % 16)});
            cfg_n++;
        end
        if (o_rsp_valid === 1'b1) begin
            rsp_n++;
            e = q.pop_front();
            chk("rsp_id", {16'h0, o_rsp_id}, {16'h0, e.id});
            chk("rsp_src", {16'h0, o_rsp_src}, {16'h0, e.src});
            if (e.ck)
                chk("rsp_payload", o_rsp_payload, e.pl);
        end
    end
    task automatic send(input logic [15:0] id, d, input logic [31:0] p,
                        input logic [15:0] xid, input logic [31:0] xp, input logic ck);
        int n;
        n = rsp_n;
        q.push_back('{xid, d, xp, ck});
        @(posedge i_clk);
        i_cmd_valid <= 1'b1;
        i_cmd_id <= id;
        i_cmd_dst <= d;
        i_cmd_payload <= p;
        @(posedge i_clk);
        i_cmd_valid <= 1'b0;
        for (int i = 0; i < 200 && rsp_n == n; i++) @(posedge i_clk) #1;
        if (rsp_n == n) begin
            fail_count++;
            final_report();
        end
    endtask
    task automatic cfg_wait(input int base);
        for (int i = 0; i < 200 && cfg_n - base < 16; i++) @(posedge i_clk) #1;
        chk("cfg_words", cfg_n - base, 16);
    endtask
    // Main sequence of scenarios.
    initial begin
        r = $random(seed);
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        cfg_wait(0);
        for (k = 4; k <= 10; k += 2)
            send(16'(k), 0, $random(seed), 16'h8000 | 16'(k), 0, 1);
        $display("test reset values done");
        for (k = 0; k < 3; k++) begin
            r = $random(seed);
            r[3:0] = 4'(k);
            send(CMD_MODE_WR, 0, r, 16'h8003, 0, 0);
            send(CMD_MODE_RD, 0, r, 16'h8004, k, 1);
            chk("mode", {28'h0, o_mode}, k);
        end
        send(CMD_MODE_WR, 0, 32'h1, 16'h8003, 0, 0);
        send(CMD_SET_WR, 0, 32'h02000101, 16'h8005, 0, 0);
        send(CMD_SET_RD, 0, r, 16'h8006, 32'h02000101, 1);
        chk("settings", o_settings, 32'h02000101);
        send(CMD_MODE_WR, 0, 32'h2, 16'h8003, 0, 0);
        m = $random(seed);
        m[3:0] = 4'h2 + m[7:4] % 4'he;
        send(CMD_SET_WR, 0, m, 16'h8005, 0, 0);
        send(CMD_SET_RD, 0, r, 16'h8006, m, 1);
        $display("test mode and settings done");
        for (k = 1; k < 4; k++) begin
            send(CMD_ACT_WR, 0, {28'hfedcba9, 4'(k % 3)}, 16'h8007, 0, 0);
            send(CMD_ACT_RD, 0, r, 16'h8008, k % 3, 1);
            chk("acq_run", {31'h0, o_acq_run}, {31'h0, k == 2});
        end
        send(CMD_MODE_RD, 0, r, 16'h8004, 0, 1);
        send(CMD_SET_RD, 0, r, 16'h8006, 0, 1);
        $display("test actions done");
        m = $random(seed);
        send(CMD_MASK_WR, 0, m, 16'h8009, 0, 0);
        send(CMD_PING, 0, r, 16'h8001, 0, 1);
        send(CMD_MASK_RD, 0, r, 16'h800a, m, 1);
        chk("mask", o_trig_mask, m);
        send(16'h000b, 0, r, ERR_UNKNOWN, 0, 0);
        $display("test local commands done");
        send(CMD_PING, 16'h0002, r, 16'h8001, r + 1, 1);
        send(CMD_MASK_RD, 16'h8003, r, 16'h800a, r + 1, 1);
        chk("bcast", {31'h0, o_child_bcast}, 1);
        slow <= 1'b1;
        send(16'h1001, 16'h0002, r, 16'h9001, 0, 0);
        slow <= 1'b0;
        send(CMD_PING, 16'h0002, r, ERR_CHILD_BUSY, 0, 0);
        send(CMD_PING, 16'h0004, m, 16'h8001, m + 1, 1);
        repeat (40) @(posedge i_clk);
        send(CMD_PING, 16'h0002, m, 16'h8001, m + 1, 1);
        $display("test child commands done");
        k = cfg_n;
        send(CMD_CFG_CHILD, 0, r, 16'h8002, 0, 0);
        cfg_wait(k);
        $display("test configure children done");
        final_report();
    end
endmodule
